// ===== core_exec_pkg.sv
// constants and types shared by the execution subset
// assumes a 14-bit instruction word and 7-bit file addresses
package core_exec_pkg;
   localparam int INSTR_W = 14;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   // opcode fields
   localparam logic [5:0] OPC_ADD_ACC_REG = 6'h07;
   localparam logic [5:0] OPC_AND_ACC_REG = 6'h05;
   localparam logic [3:0] OPC_SET_REG_BIT = 4'h5;
   localparam logic [3:0] OPC_SKIP_BIT_ZERO = 4'h6;
   localparam logic [3:0] OPC_SKIP_BIT_ONE = 4'h7;
   localparam logic [5:0] OPC_AND_IMM_ACC = 6'h39;
   localparam logic [13:0] OPC_KICK_DOG = 14'h0064;
   // field positions
   localparam int DEST_BIT = 7;
   localparam int BITSEL_LSB = 7;
   // reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] DOG_CLEAR = 8'h00;
   // one-cycle skip slot
   localparam int SKIP_CYCLES = 1;
   typedef enum logic [2:0] {
      OP_NONE, OP_ADD, OP_ANDR, OP_ANDL, OP_BSET, OP_SKZ, OP_SKO, OP_KICK
   } op_t;
endpackage

// ===== core_instr_exec_subset.sv
// executes a subset of the 8-bit core instruction set
// assumes the file data is read combinationally at o_rd_addr
`timescale 1ns/10ps
module core_instr_exec_subset
   import core_exec_pkg::*;
#(
   parameter logic [ADDR_W-1:0] PORT_ADDR = 7'h05,
   parameter logic [ADDR_W-1:0] TIMER_ZERO_ADDR = 7'h01
)(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_instr_valid,
   input wire logic [INSTR_W-1:0] i_instr,
   input wire logic [DATA_W-1:0] i_rd_data,
   input wire logic [DATA_W-1:0] i_port_pins,
   input wire logic i_psc_on_timer_zero,
   output logic [ADDR_W-1:0] o_rd_addr,
   output logic o_wr_en,
   output logic [ADDR_W-1:0] o_wr_addr,
   output logic [DATA_W-1:0] o_wr_data,
   output logic [DATA_W-1:0] o_acc,
   output logic o_carry,
   output logic o_nibble_overflow_bit,
   output logic o_zero,
   output logic o_dog_expired_flag,
   output logic o_power_down_flag,
   output logic o_dog_clear,
   output logic o_timer_zero_psc_clear,
   output logic o_skip_slot
);
   op_t op;
   logic [1:0] pin_s1_q [DATA_W];
   logic [DATA_W-1:0] pins_q;
   logic [DATA_W-1:0] operand;
   logic [DATA_W:0] sum;
   logic [4:0] nib_sum;
   logic [DATA_W-1:0] and_r;
   logic [DATA_W-1:0] and_l;
   logic bit_val;
   logic dest_reg;
   logic exec;

   instr_decode u_dec (
      .i_instr(i_instr),
      .o_op(op)
   );

   // two-stage pin synchroniser
   genvar g;
   for (g = 0; g < DATA_W; g++) begin : g_sync
      always_ff @(posedge i_mclk) begin
         if (i_sys_rst) begin
            pin_s1_q[g] <= 2'h0;
         end else begin
            pin_s1_q[g] <= {pin_s1_q[g][0], i_port_pins[g]};
         end
      end
      assign pins_q[g] = pin_s1_q[g][1];
   end

   // operand select and arithmetic
   assign o_rd_addr = i_instr[ADDR_W-1:0];
   assign operand = (o_rd_addr == PORT_ADDR) ? pins_q : i_rd_data;
   assign sum = {1'b0, o_acc} + {1'b0, operand};
   assign nib_sum = {1'b0, o_acc[3:0]} + {1'b0, operand[3:0]};
   assign and_r = o_acc & operand;
   assign and_l = o_acc & i_instr[DATA_W-1:0];
   assign bit_val = operand[i_instr[BITSEL_LSB+:3]];
   assign dest_reg = i_instr[DEST_BIT];
   assign exec = i_instr_valid && !o_skip_slot;

   // skip slot: next instruction becomes a no-op
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_skip_slot <= 1'b0;
      end else if (exec && op == OP_SKZ) begin
         o_skip_slot <= !bit_val;
      end else if (exec && op == OP_SKO) begin
         o_skip_slot <= bit_val;
      end else if (i_instr_valid) begin
         o_skip_slot <= 1'b0;
      end
   end

   // accumulator and flags
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_acc <= ACC_RST;
         o_carry <= 1'b0;
         o_nibble_overflow_bit <= 1'b0;
         o_zero <= 1'b0;
      end else if (exec) begin
         case (op)
            OP_ADD: begin
               if (!dest_reg) begin
                  o_acc <= sum[DATA_W-1:0];
               end
               o_carry <= sum[DATA_W];
               o_nibble_overflow_bit <= nib_sum[4];
               o_zero <= (sum[DATA_W-1:0] == 8'h00);
            end
            OP_ANDR: begin
               if (!dest_reg) begin
                  o_acc <= and_r;
               end
               o_zero <= (and_r == 8'h00);
            end
            OP_ANDL: begin
               o_acc <= and_l;
               o_zero <= (and_l == 8'h00);
            end
            default: begin
            end
         endcase
      end
   end

   // file register write-back
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_wr_en <= 1'b0;
         o_wr_addr <= '0;
         o_wr_data <= 8'h00;
         o_timer_zero_psc_clear <= 1'b0;
      end else begin
         o_wr_en <= 1'b0;
         o_timer_zero_psc_clear <= 1'b0;
         o_wr_addr <= o_rd_addr;
         if (exec && ((op == OP_ADD || op == OP_ANDR) && dest_reg || op == OP_BSET)) begin
            o_wr_en <= 1'b1;
            o_timer_zero_psc_clear <= (o_rd_addr == TIMER_ZERO_ADDR) && i_psc_on_timer_zero;
            if (op == OP_ADD) begin
               o_wr_data <= sum[DATA_W-1:0];
            end else if (op == OP_ANDR) begin
               o_wr_data <= and_r;
            end else begin
               o_wr_data <= operand | (8'h01 << i_instr[BITSEL_LSB+:3]);
            end
         end
      end
   end

   // watchdog kick and status bits
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_dog_clear <= 1'b0;
         o_dog_expired_flag <= 1'b1;
         o_power_down_flag <= 1'b1;
      end else begin
         o_dog_clear <= exec && op == OP_KICK;
         if (exec && op == OP_KICK) begin
            o_dog_expired_flag <= 1'b1;
            o_power_down_flag <= 1'b1;
         end
      end
   end

   // checks
   sequence s_kick;
      exec && op == OP_KICK;
   endsequence
   property p_kick;
      @(posedge i_mclk) disable iff (i_sys_rst)
         s_kick |=> o_dog_clear && o_dog_expired_flag && o_power_down_flag;
   endproperty
   a_kick: assert property (p_kick) else $error("kick not applied");
   property p_dog;
      @(posedge i_mclk) disable iff (i_sys_rst) !(exec && op == OP_KICK) |=> !o_dog_clear;
   endproperty
   a_dog: assert property (p_dog) else $error("dog clear not a pulse");
   property p_add;
      @(posedge i_mclk) disable iff (i_sys_rst)
         exec && op == OP_ADD && !dest_reg |=> o_acc == $past(sum[7:0]) && o_carry == $past(sum[8]);
   endproperty
   a_add: assert property (p_add) else $error("add result wrong");
   property p_bset;
      @(posedge i_mclk) disable iff (i_sys_rst)
         exec && op == OP_BSET |=> o_wr_en && o_wr_data[$past(i_instr[9:7])]
            && $stable(o_zero) && $stable(o_carry);
   endproperty
   a_bset: assert property (p_bset) else $error("bit set wrong");
   property p_andl;
      @(posedge i_mclk) disable iff (i_sys_rst)
         exec && op == OP_ANDL |=> o_zero == (o_acc == 8'h00) && $stable(o_carry);
   endproperty
   a_andl: assert property (p_andl) else $error("and literal flags wrong");
   property p_andr;
      @(posedge i_mclk) disable iff (i_sys_rst)
         exec && op == OP_ANDR && dest_reg |=> o_wr_en && o_wr_data == $past(and_r);
   endproperty
   a_andr: assert property (p_andr) else $error("and register write wrong");
   property p_skz;
      @(posedge i_mclk) disable iff (i_sys_rst)
         exec && op == OP_SKZ |=> o_skip_slot == !$past(bit_val);
   endproperty
   a_skz: assert property (p_skz) else $error("skip on zero wrong");
   property p_sko;
      @(posedge i_mclk) disable iff (i_sys_rst)
         exec && op == OP_SKO |=> o_skip_slot == $past(bit_val);
   endproperty
   a_sko: assert property (p_sko) else $error("skip on one wrong");
   property p_tmr;
      @(posedge i_mclk) disable iff (i_sys_rst)
         o_timer_zero_psc_clear |-> o_wr_en && o_wr_addr == TIMER_ZERO_ADDR;
   endproperty
   a_tmr: assert property (p_tmr) else $error("timer prescaler clear stray");
endmodule

// ===== instr_decode.sv
// instruction decoder for the execution subset
// assumes a valid instruction word from the fetch stage
`timescale 1ns/10ps
module instr_decode
   import core_exec_pkg::*;
(
   input wire logic [INSTR_W-1:0] i_instr,
   output core_exec_pkg::op_t o_op
);
   // opcode match
   always_comb begin
      if (i_instr == OPC_KICK_DOG) begin
         o_op = OP_KICK;
      end else if (i_instr[13:8] == OPC_ADD_ACC_REG) begin
         o_op = OP_ADD;
      end else if (i_instr[13:8] == OPC_AND_ACC_REG) begin
         o_op = OP_ANDR;
      end else if (i_instr[13:8] == OPC_AND_IMM_ACC) begin
         o_op = OP_ANDL;
      end else if (i_instr[13:10] == OPC_SET_REG_BIT) begin
         o_op = OP_BSET;
      end else if (i_instr[13:10] == OPC_SKIP_BIT_ZERO) begin
         o_op = OP_SKZ;
      end else if (i_instr[13:10] == OPC_SKIP_BIT_ONE) begin
         o_op = OP_SKO;
      end else begin
         o_op = OP_NONE;
      end
   end
endmodule

// ===== tb_top.sv
// self-checking bench for the instruction execution subset
// assumes file data and pins are modelled by the bench, driven on the falling edge
`timescale 1ns/10ps
module tb_top;
   import core_exec_pkg::*;
   logic i_mclk;
   logic i_sys_rst;
   logic i_instr_valid;
   logic [INSTR_W-1:0] i_instr;
   logic [DATA_W-1:0] i_rd_data;
   logic [DATA_W-1:0] i_port_pins;
   logic i_psc_on_timer_zero;
   logic [ADDR_W-1:0] o_rd_addr;
   logic o_wr_en;
   logic [ADDR_W-1:0] o_wr_addr;
   logic [DATA_W-1:0] o_wr_data;
   logic [DATA_W-1:0] o_acc;
   logic o_carry;
   logic o_nibble_overflow_bit;
   logic o_zero;
   logic o_dog_expired_flag;
   logic o_power_down_flag;
   logic o_dog_clear;
   logic o_timer_zero_psc_clear;
   logic o_skip_slot;
   int n_errors = 0;
   int check_count = 0;

   // device under test, port at 05h and timer_zero at 01h
   core_instr_exec_subset #(.PORT_ADDR(7'h05), .TIMER_ZERO_ADDR(7'h01)) u_core_instr_exec_subset (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_instr_valid(i_instr_valid),
      .i_instr(i_instr), .i_rd_data(i_rd_data), .i_port_pins(i_port_pins),
      .i_psc_on_timer_zero(i_psc_on_timer_zero), .o_rd_addr(o_rd_addr),
      .o_wr_en(o_wr_en),
      .o_wr_addr(o_wr_addr), .o_wr_data(o_wr_data), .o_acc(o_acc), .o_carry(o_carry),
      .o_nibble_overflow_bit(o_nibble_overflow_bit), .o_zero(o_zero),
      .o_dog_expired_flag(o_dog_expired_flag), .o_power_down_flag(o_power_down_flag),
      .o_dog_clear(o_dog_clear), .o_timer_zero_psc_clear(o_timer_zero_psc_clear),
      .o_skip_slot(o_skip_slot));

   // 8 ns clock
   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end

   // compare one value and count
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one instruction for one cycle, outputs settled on return
   task automatic run(input logic [13:0] ins, input logic [7:0] rd);
      @(negedge i_mclk);
      i_instr_valid = 1'b1;
      i_instr = ins;
      i_rd_data = rd;
      #1;
      chk("rd_addr", {1'b0, o_rd_addr}, {1'b0, ins[6:0]});
      @(negedge i_mclk);
      i_instr_valid = 1'b0;
   endtask

   // accumulator and arithmetic flags
   task automatic st(input logic [7:0] a, input logic c, input logic nib, input logic z);
      chk("acc", o_acc, a);
      chk("carry", {7'h00, o_carry}, {7'h00, c});
      chk("nibble", {7'h00, o_nibble_overflow_bit}, {7'h00, nib});
      chk("zero", {7'h00, o_zero}, {7'h00, z});
   endtask

   // file write pulse
   task automatic wr(input logic en, input logic [6:0] ad, input logic [7:0] d);
      chk("wr_en", {7'h00, o_wr_en}, {7'h00, en});
      if (en) begin
         chk("wr_addr", {1'b0, o_wr_addr}, {1'b0, ad});
         chk("wr_data", o_wr_data, d);
      end
   endtask

   // verdict
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      i_sys_rst = 1'b1;
      i_instr_valid = 1'b0;
      i_instr = 14'h0000;
      i_rd_data = 8'h00;
      i_port_pins = 8'h5A;
      i_psc_on_timer_zero = 1'b0;
      repeat (3) @(negedge i_mclk);
      i_sys_rst = 1'b0;
      st(8'h00, 1'b0, 1'b0, 1'b0);
      chk("expired", {7'h00, o_dog_expired_flag}, 8'h01);
      chk("skip", {7'h00, o_skip_slot}, 8'h00);
      run({OPC_ADD_ACC_REG, 1'b0, 7'h20}, 8'h3C);
      st(8'h3C, 1'b0, 1'b0, 1'b0);
      run({OPC_ADD_ACC_REG, 1'b0, 7'h21}, 8'hC8);
      st(8'h04, 1'b1, 1'b1, 1'b0);
      run({OPC_ADD_ACC_REG, 1'b1, 7'h22}, 8'hFC);
      st(8'h04, 1'b1, 1'b1, 1'b1);
      wr(1'b1, 7'h22, 8'h00);
      run({OPC_AND_IMM_ACC, 8'hFF}, 8'h00);
      st(8'h04, 1'b1, 1'b1, 1'b0);
      wr(1'b0, 7'h00, 8'h00);
      run({OPC_AND_ACC_REG, 1'b1, 7'h23}, 8'hF0);
      st(8'h04, 1'b1, 1'b1, 1'b1);
      wr(1'b1, 7'h23, 8'h00);
      run({OPC_AND_ACC_REG, 1'b0, 7'h24}, 8'h06);
      st(8'h04, 1'b1, 1'b1, 1'b0);
      for (int b = 0; b < 8; b++) begin
         run({OPC_SET_REG_BIT, b[2:0], 7'h30}, 8'h00);
         wr(1'b1, 7'h30, 8'h01 << b);
         st(8'h04, 1'b1, 1'b1, 1'b0);
      end
      run({OPC_SET_REG_BIT, 3'd0, 7'h05}, 8'h00);
      wr(1'b1, 7'h05, 8'h5B);
      i_psc_on_timer_zero = 1'b1;
      run({OPC_ADD_ACC_REG, 1'b1, 7'h01}, 8'h00);
      chk("psc_clear", {7'h00, o_timer_zero_psc_clear}, 8'h01);
      i_psc_on_timer_zero = 1'b0;
      run({OPC_ADD_ACC_REG, 1'b1, 7'h01}, 8'h00);
      chk("psc_clear", {7'h00, o_timer_zero_psc_clear}, 8'h00);
      run({OPC_SKIP_BIT_ZERO, 3'd3, 7'h10}, 8'hF7);
      chk("skip", {7'h00, o_skip_slot}, 8'h01);
      run({OPC_ADD_ACC_REG, 1'b1, 7'h11}, 8'h01);
      chk("skip", {7'h00, o_skip_slot}, 8'h00);
      wr(1'b0, 7'h00, 8'h00);
      st(8'h04, 1'b0, 1'b0, 1'b0);
      run({OPC_SKIP_BIT_ZERO, 3'd3, 7'h10}, 8'h08);
      chk("skip", {7'h00, o_skip_slot}, 8'h00);
      run({OPC_SKIP_BIT_ONE, 3'd7, 7'h10}, 8'h80);
      chk("skip", {7'h00, o_skip_slot}, 8'h01);
      run({OPC_AND_IMM_ACC, 8'h00}, 8'h00);
      st(8'h04, 1'b0, 1'b0, 1'b0);
      run({OPC_SKIP_BIT_ONE, 3'd7, 7'h10}, 8'h7F);
      chk("skip", {7'h00, o_skip_slot}, 8'h00);
      run({OPC_AND_IMM_ACC, 8'h00}, 8'h00);
      st(8'h00, 1'b0, 1'b0, 1'b1);
      run(14'h3FFF, 8'hFF);
      st(8'h00, 1'b0, 1'b0, 1'b1);
      wr(1'b0, 7'h00, 8'h00);
      run(OPC_KICK_DOG, 8'h00);
      chk("dog_clear", {7'h00, o_dog_clear}, 8'h01);
      chk("expired", {7'h00, o_dog_expired_flag}, 8'h01);
      chk("power_down", {7'h00, o_power_down_flag}, 8'h01);
      @(negedge i_mclk);
      chk("dog_clear", {7'h00, o_dog_clear}, 8'h00);
      complete_run();
   end
endmodule
